// ==== hw/line_supervision_detectors.sv ====
// Line supervision detectors: hook, ground key, ring trip, test load
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Debounce timer counted in millisecond ticks
module debounce_timer (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Timing
   input wire logic tick,
   input wire logic [5:0] target,
   // Comparator and result
   input wire logic raw,
   output logic state,
   output logic change
);
   logic [5:0] cnt;
   wire [5:0] cnt_inc = cnt + 6'h01;
   wire expired = tick && (cnt_inc >= target);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 6'h00;
         state <= 1'b0;
         change <= 1'b0;
      end else begin
         change <= 1'b0;
         if (raw == state) begin
            cnt <= 6'h00;
         end else if (expired) begin
            cnt <= 6'h00;
            state <= raw;
            change <= 1'b1;
         end else if (tick) begin
            cnt <= cnt_inc;
         end
      end
   end
endmodule : debounce_timer

// How it works
// - Compare longitudinal current with ground key threshold
// - Debounce ground key result by programmed time
// - Ground key change interrupts only when unmasked
// - Supervision threshold three bits, 8 to 15 mA
// - Supervision debounce five bits, 12 to 62 ms
// - Ground key threshold three bits, 0 to 42 mA
// - Ground key debounce five bits, 4 to 28 ms
// - Compare tip-ring current with ring trip threshold
// - Judge ring trip once per ringing cycle
// - Over half cycle near limit gives trip
// - Two consecutive trip cycles after the first ringing cycle declare ring trip
// - Ring trip threshold in 0.5 mA steps
// - Current limit 2 mA steps from 50 mA
// - AC mode averages half-wave rectified current
// - Loop closure flag in signalling register interrupts
// - Reset selects AC averaging ring trip detection, near-limit check still active
// - Off-hook detector compares and debounces tip-ring current
module line_supervision_detectors #(
   parameter int CHANNELS = supervision_pkg::CHANNELS_DEF,
   parameter int MS_CYCLES = supervision_pkg::MS_CYCLES_DEF
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Line measurements, 0.5 mA units
   input wire logic [CHANNELS-1:0][8:0] loop_current,
   input wire logic [CHANNELS-1:0][7:0] long_current,
   input wire logic sample_strobe,
   input wire logic [CHANNELS-1:0] ringing,
   input wire logic [CHANNELS-1:0] ring_cycle_mark,
   // Host interrupt and test load switches
   output logic irq,
   output logic [CHANNELS-1:0] test_load_across,
   output logic [CHANNELS-1:0] test_load_ground
);
   import supervision_pkg::*;
   if (CHANNELS < 1 || CHANNELS > 2) $error("CHANNELS must be 1 or 2");
   if (MS_CYCLES < 2) $error("MS_CYCLES must be at least 2");

   // ==========================================================
   // Millisecond tick
   logic [31:0] ms_cnt;
   logic tick;
   wire ms_last = (ms_cnt == 32'(MS_CYCLES - 1));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_cnt <= 32'h0000_0000;
         tick <= 1'b0;
      end else begin
         ms_cnt <= ms_last ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
         tick <= ms_last;
      end
   end
   // ==========================================================
   // Bus decode
   wire wr_fire = awready;
   wire wr_ch = awaddr[CH_BIT];
   wire [2:0] wr_idx = awaddr[4:2];
   wire wr_map = (awaddr[31:MAP_TOP_BIT] == '0) && (wr_idx <= REG_ICR)
                 && (32'(wr_ch) < 32'(CHANNELS));
   wire rd_ch = araddr[CH_BIT];
   wire [2:0] rd_idx = araddr[4:2];
   wire rd_map = (araddr[31:MAP_TOP_BIT] == '0) && (rd_idx <= REG_ICR)
                 && (32'(rd_ch) < 32'(CHANNELS));
   wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
   logic [31:0] sup_reg [CHANNELS];
   logic [31:0] ring_reg [CHANNELS];
   logic [31:0] mask_reg [CHANNELS];
   logic [31:0] icr_reg [CHANNELS];
   event_t ev_reg [CHANNELS];
   logic [CHANNELS-1:0] hook_st;
   logic [CHANNELS-1:0] gk_st;
   logic [CHANNELS-1:0] ch_irq;
   logic [31:0] sig_word [CHANNELS];
   // ==========================================================
   // Per-channel detectors and registers
   for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
      wire wsel = wr_fire && wr_map && (32'(wr_ch) == g);
      wire [2:0] supervision_threshold = sup_reg[g][TSH_LSB +: 3];
      wire [4:0] supervision_debounce = sup_reg[g][DSH_LSB +: 5];
      wire [2:0] ground_key_threshold = sup_reg[g][TGK_LSB +: 3];
      wire [4:0] ground_key_debounce = sup_reg[g][DGK_LSB +: 5];
      wire [6:0] ring_trip_threshold = ring_reg[g][RING_TRIP_THRESHOLD_LSB +: 7];
      wire ac_mode = ring_reg[g][MODE_BIT];
      wire [4:0] ringing_current_limit = ring_reg[g][ILR_LSB +: 5];
      wire signed [8:0] cur = loop_current[g];
      wire [7:0] rect = cur[8] ? 8'h00 : cur[7:0];
      wire [8:0] neg_cur = -cur;
      wire [7:0] mag = cur[8] ? neg_cur[7:0] : cur[7:0];
      // Threshold levels
      wire [7:0] sup_level = SUP_BASE + {4'h0, supervision_threshold, 1'b0};
      wire [7:0] gk_level = 8'(GK_STEP * {5'h00, ground_key_threshold});
      wire [7:0] rt_level = {1'b0, ring_trip_threshold};
      wire [7:0] ilr_level = ILR_BASE + {1'b0, ringing_current_limit, 2'b00};
      wire [7:0] near_level = ilr_level - NEAR_MARGIN;
      // Debounce lengths in ms, clamped so no code misbehaves
      wire [5:0] dsh_raw = {supervision_debounce, 1'b0};
      wire [5:0] dsh_ms = (dsh_raw < DSH_MIN) ? DSH_MIN :
                          (dsh_raw > DSH_MAX) ? DSH_MAX : dsh_raw;
      wire [5:0] dgk_raw = {1'b0, ground_key_debounce};
      wire [5:0] dgk_ms = (dgk_raw < DGK_MIN) ? DGK_MIN :
                          (dgk_raw > DGK_MAX) ? DGK_MAX : dgk_raw;
      wire hook_raw = mag >= sup_level;
      wire gk_raw = long_current[g] >= gk_level;
      logic hook_chg;
      logic gk_chg;
      debounce_timer u_hook (
         .aclk(aclk),
         .aresetn(aresetn),
         .tick(tick),
         .target(dsh_ms),
         .raw(hook_raw),
         .state(hook_st[g]),
         .change(hook_chg)
      );
      debounce_timer u_gk (
         .aclk(aclk),
         .aresetn(aresetn),
         .tick(tick),
         .target(dgk_ms),
         .raw(gk_raw),
         .state(gk_st[g]),
         .change(gk_chg)
      );
      // Ring trip: accumulate over one ringing cycle
      logic [23:0] sum;
      logic [23:0] thr_sum;
      logic [15:0] n_tot;
      logic [15:0] n_over;
      logic [15:0] n_near;
      logic started;
      logic prev_trip;
      logic rt_ev;
      wire avg_over = sum > thr_sum;
      wire maj_over = {n_over, 1'b0} > {1'b0, n_tot};
      wire maj_near = {n_near, 1'b0} > {1'b0, n_tot};
      wire trip_ind = (ac_mode ? avg_over : maj_over) || maj_near;
      wire judge = ringing[g] && ring_cycle_mark[g];
      always_ff @(posedge aclk) begin
         if (!aresetn || !ringing[g] || judge) begin
            sum <= 24'h00_0000;
            thr_sum <= 24'h00_0000;
            n_tot <= 16'h0000;
            n_over <= 16'h0000;
            n_near <= 16'h0000;
         end else if (sample_strobe) begin
            sum <= sum + {16'h0000, rect};
            thr_sum <= thr_sum + {16'h0000, rt_level};
            n_tot <= n_tot + 16'h0001;
            n_over <= n_over + {15'h0000, mag >= rt_level};
            n_near <= n_near + {15'h0000, mag >= near_level};
         end
      end
      always_ff @(posedge aclk) begin
         if (!aresetn || !ringing[g]) begin
            started <= 1'b0;
            prev_trip <= 1'b0;
            rt_ev <= 1'b0;
         end else begin
            rt_ev <= judge && started && trip_ind && prev_trip;
            if (judge) begin
               started <= 1'b1;
               prev_trip <= started && trip_ind;
            end
         end
      end
      // Sticky events: loop closure, hook change, ground key change
      wire [2:0] ev_set = {gk_chg, hook_chg, rt_ev};
      wire [2:0] ev_clr = (wsel && wr_idx == REG_SIG && wstrb[0]) ?
                          wdata[SIG_EV_LSB +: 3] : 3'h0;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            sup_reg[g] <= SUP_RST;
            ring_reg[g] <= RING_RST;
            mask_reg[g] <= 32'h0000_0000;
            icr_reg[g] <= 32'h0000_0000;
            ev_reg[g] <= 3'h0;
         end else begin
            // A new event wins over a clear in the same cycle
            ev_reg[g] <= (ev_reg[g] & ~ev_clr) | ev_set;
            if (wsel && wr_idx == REG_SUP) begin
               sup_reg[g] <= (sup_reg[g] & ~wmask) | (wdata & wmask);
            end
            if (wsel && wr_idx == REG_RING) begin
               ring_reg[g] <= (ring_reg[g] & ~wmask) | (wdata & wmask);
            end
            if (wsel && wr_idx == REG_MASK) begin
               mask_reg[g] <= (mask_reg[g] & ~wmask) | (wdata & wmask);
            end
            if (wsel && wr_idx == REG_ICR) begin
               icr_reg[g] <= (icr_reg[g] & ~wmask) | (wdata & wmask);
            end
         end
      end
      assign ch_irq[g] = |(ev_reg[g] & ~mask_reg[g][2:0]);
      assign sig_word[g] = {27'h000_0000, ev_reg[g], gk_st[g], hook_st[g]};
      // Test load switch selection
      wire tl_en = icr_reg[g][TL_MASK_LO] && icr_reg[g][TL_MASK_HI];
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            test_load_across[g] <= 1'b0;
            test_load_ground[g] <= 1'b0;
         end else begin
            test_load_across[g] <= tl_en && icr_reg[g][TL_CTRL_LO]
                                   && !icr_reg[g][TL_CTRL_HI];
            test_load_ground[g] <= tl_en && !icr_reg[g][TL_CTRL_LO]
                                   && icr_reg[g][TL_CTRL_HI];
         end
      end
   end

   // ==========================================================
   // Read selection
   logic [31:0] rd_word;
   wire rd_c = (CHANNELS > 1) ? rd_ch : 1'b0;
   always_comb begin
      rd_word = 32'h0000_0000;
      if (rd_map) begin
         unique case (rd_idx)
            REG_SUP: rd_word = sup_reg[rd_c];
            REG_RING: rd_word = ring_reg[rd_c];
            REG_SIG: rd_word = sig_word[rd_c];
            REG_MASK: rd_word = mask_reg[rd_c];
            REG_ICR: rd_word = icr_reg[rd_c];
            default: rd_word = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // AXI4-Lite handshakes; one write and one read at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         awready <= awvalid && wvalid && !awready && !bvalid;
         wready <= awvalid && wvalid && !awready && !bvalid;
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
         irq <= 1'b0;
      end else begin
         arready <= arvalid && !arready && !rvalid;
         irq <= |ch_irq;
         if (arready) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule : line_supervision_detectors

`default_nettype wire

// ==== hw/supervision_pkg.sv ====
// Constants shared by the line supervision detector block
package supervision_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_MS = 1;
   localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
   localparam int CHANNELS_DEF = 2;
   // ==========================================================
   // Register map, word indices within one channel window
   localparam logic [31:0] CH_STRIDE = 32'h0000_0020;
   localparam int CH_BIT = 5;
   localparam int MAP_TOP_BIT = 6;
   localparam logic [2:0] REG_SUP = 3'h0;
   localparam logic [2:0] REG_RING = 3'h1;
   localparam logic [2:0] REG_SIG = 3'h2;
   localparam logic [2:0] REG_MASK = 3'h3;
   localparam logic [2:0] REG_ICR = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Field positions
   localparam int TSH_LSB = 0;
   localparam int DSH_LSB = 3;
   localparam int TGK_LSB = 8;
   localparam int DGK_LSB = 11;
   localparam int RING_TRIP_THRESHOLD_LSB = 0;
   localparam int MODE_BIT = 7;
   localparam int ILR_LSB = 8;
   localparam int SIG_HOOK_BIT = 0;
   localparam int SIG_GK_BIT = 1;
   localparam int SIG_EV_LSB = 2;
   localparam int TL_MASK_LO = 22;
   localparam int TL_MASK_HI = 23;
   localparam int TL_CTRL_LO = 30;
   localparam int TL_CTRL_HI = 31;
   // ==========================================================
   // Reset values
   localparam logic [31:0] SUP_RST = 32'h0000_8352;
   localparam logic [31:0] RING_RST = 32'h0000_0AA8;
   // ==========================================================
   // Current scaling, all levels in 0.5 mA units; debounce limits in ms
   localparam logic [7:0] SUP_BASE = 8'h10;
   localparam logic [7:0] GK_STEP = 8'h0C;
   localparam logic [7:0] ILR_BASE = 8'h64;
   localparam logic [7:0] NEAR_MARGIN = 8'h08;
   localparam logic [5:0] DSH_MIN = 6'h0C;
   localparam logic [5:0] DSH_MAX = 6'h3E;
   localparam logic [5:0] DGK_MIN = 6'h04;
   localparam logic [5:0] DGK_MAX = 6'h1C;
   typedef logic [2:0] event_t;
endpackage : supervision_pkg

// ==== sim/host_bus_model.sv ====
// Host side register bus master model
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
module host_bus_model (
   // Clock
   input wire logic aclk,
   // Write channels
   output logic [31:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic [31:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   int lost = 0;
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hF;
   end
   task automatic write_word(input logic [31:0] a, input logic [31:0] d,
                             output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin @(posedge aclk); n++; end while (!(awready && wready) && n < 50);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (!bvalid && n < 50) begin @(posedge aclk); n++; end
      r = bresp;
      bready <= 1'b0;
      if (n >= 50) lost++;
   endtask : write_word
   task automatic read_word(input logic [31:0] a, output logic [31:0] d,
                            output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin @(posedge aclk); n++; end while (!arready && n < 50);
      arvalid <= 1'b0;
      while (!rvalid && n < 50) begin @(posedge aclk); n++; end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 50) lost++;
   endtask : read_word
endmodule : host_bus_model
`default_nettype wire

// ==== sim/line_supervision_detectors_monitor.sv ====
// Bus and test load assertions for the line supervision detectors
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
module line_supervision_detectors_monitor
   import supervision_pkg::*;
#(
   parameter int CHANNELS = CHANNELS_DEF
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   // Test load switches
   input wire logic [CHANNELS-1:0] test_load_across,
   input wire logic [CHANNELS-1:0] test_load_ground
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_follows; awready |=> bvalid; endproperty
   a_b_follows: assert property (p_b_follows) else $error("write answer late");
   property p_r_follows; arready |=> rvalid; endproperty
   a_r_follows: assert property (p_r_follows) else $error("read answer late");
   property p_b_holds; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_holds: assert property (p_b_holds) else $error("write answer dropped");
   property p_r_holds;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_r_holds: assert property (p_r_holds) else $error("read answer dropped");
   property p_w_pair; awready |-> wready && awvalid && wvalid; endproperty
   a_w_pair: assert property (p_w_pair) else $error("write halves split");
   property p_aw_pulse; awready |=> !awready && !wready; endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("accept held");
   property p_b_blocks; bvalid |-> !awready; endproperty
   a_b_blocks: assert property (p_b_blocks) else $error("write taken while busy");
   property p_err_zero; rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
   property p_load_excl; (test_load_across & test_load_ground) == '0; endproperty
   a_load_excl: assert property (p_load_excl) else $error("both loads on");
endmodule : line_supervision_detectors_monitor
bind line_supervision_detectors line_supervision_detectors_monitor #(
   .CHANNELS(CHANNELS)
) i_mon (.*);
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking testbench for the line supervision detectors
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
module testbench;
   import supervision_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr, wdata, araddr, rdata, got;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp, test_load_across, test_load_ground;
   logic [1:0][8:0] loop_current = '0;
   logic [1:0][7:0] long_current = '0;
   logic sample_strobe = 1'b0;
   logic [1:0] ringing = '0;
   logic [1:0] ring_cycle_mark = '0;
   int errors = 0;
   int total_checks = 0;
   always #12.5 aclk = ~aclk;
   line_supervision_detectors #(.CHANNELS(2), .MS_CYCLES(4)) i_line_supervision_detectors (.*);
   host_bus_model host (.*);
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
      // A bus wait that ran out ends the run here
      if (host.lost > 0) conclude();
   endtask : check
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      host.read_word(a, got, resp);
      check(got & m, e);
      check({30'h0, resp}, {30'h0, RESP_OKAY});
   endtask : rd_chk
   // Polls the signalling word; running out of tries ends the run
   task automatic poll(input logic [31:0] m, input logic [31:0] e);
      int n;
      n = 0;
      do begin host.read_word(32'h08, got, resp); n++; end while ((got & m) !== e && n < 40);
      if ((got & m) !== e) begin
         errors++;
         conclude();
      end
      repeat (3) @(posedge aclk);
   endtask : poll
   task automatic reset_values();
      rd_chk(32'h00, 32'hFFFF, SUP_RST);
      rd_chk(32'h24, 32'h1FFF, RING_RST);
      rd_chk(32'h04, 32'h80, 32'h80);
      rd_chk(32'h0C, 32'h7, 32'h0);
      rd_chk(32'h10, 32'hFFFF_FFFF, 32'h0);
   endtask : reset_values
   task automatic unmapped();
      host.read_word(32'h14, got, resp);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      check(got, 32'h0);
      host.write_word(32'h14, 32'hFFFF_FFFF, resp);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
   endtask : unmapped
   task automatic test_load();
      logic [31:0] cfg [3] = '{32'h40C0_0000, 32'h80C0_0000, 32'h4000_0000};
      logic [3:0] ex [3] = '{4'h1, 4'h4, 4'h0};
      for (int k = 0; k < 3; k++) begin
         host.write_word(32'h10, cfg[k], resp);
         @(posedge aclk);
         check({28'h0, test_load_ground, test_load_across}, {28'h0, ex[k]});
      end
   endtask : test_load
   // Default debounce stays above the 4 ms floor, so only the level is moved
   task automatic ground_key();
      long_current[0] <= 8'h30;
      rd_chk(32'h08, 32'h2, 32'h0);
      poll(32'h2, 32'h2);
      rd_chk(32'h08, 32'h12, 32'h12);
      check({31'h0, irq}, 32'h1);
      host.write_word(32'h0C, 32'h4, resp);
      host.write_word(32'h08, 32'h10, resp);
      long_current[0] <= 8'h00;
      poll(32'h2, 32'h0);
      rd_chk(32'h08, 32'h10, 32'h10);
      check({31'h0, irq}, 32'h0);
   endtask : ground_key
   task automatic ring_cycle();
      repeat (8) begin
         @(posedge aclk);
         sample_strobe <= 1'b1;
         @(posedge aclk);
         sample_strobe <= 1'b0;
      end
      ring_cycle_mark <= 2'b01;
      @(posedge aclk);
      ring_cycle_mark <= 2'b00;
   endtask : ring_cycle
   // Hook and ground key events are masked so only loop closure can reach the interrupt
   task automatic ring_trip();
      host.write_word(32'h0C, 32'h6, resp);
      loop_current[0] <= 9'h050;
      ringing <= 2'b01;
      ring_cycle();
      ring_cycle();
      repeat (3) @(posedge aclk);
      rd_chk(32'h08, 32'h4, 32'h0);
      check({31'h0, irq}, 32'h0);
      ring_cycle();
      repeat (3) @(posedge aclk);
      rd_chk(32'h08, 32'h4, 32'h4);
      check({31'h0, irq}, 32'h1);
      ringing <= 2'b00;
   endtask : ring_trip
   // Each setting trips only through the path under test: a negative current
   // averages to nothing in AC mode, and stays under the threshold near the limit
   task automatic ring_trip_mode(input logic [31:0] cfg, input logic [8:0] cur);
      host.write_word(32'h04, cfg, resp);
      host.write_word(32'h08, 32'h4, resp);
      rd_chk(32'h08, 32'h4, 32'h0);
      check({31'h0, irq}, 32'h0);
      loop_current[0] <= cur;
      ringing <= 2'b01;
      repeat (3) ring_cycle();
      repeat (3) @(posedge aclk);
      rd_chk(32'h08, 32'hD, 32'hD);
      check({31'h0, irq}, 32'h1);
      ringing <= 2'b00;
   endtask : ring_trip_mode
   task automatic conclude();
      errors += host.lost;
      $display("Checks made %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      reset_values();
      unmapped();
      test_load();
      ground_key();
      ring_trip();
      ring_trip_mode(32'h0000_1F28, 9'h1A0);
      ring_trip_mode(32'h0000_00FF, 9'h060);
      conclude();
   end
endmodule : testbench
`default_nettype wire
